// *** include/ps_stage_map.svh ***
// Register offsets, reset values and timing constants of the programmable stage
`ifndef PS_STAGE_MAP_SVH
`define PS_STAGE_MAP_SVH

// ==========================================================================
// Register byte offsets (one 32-bit word each)
`define PS_CTRL        8'h00
`define PS_MODE        8'h04
`define PS_MULT0       8'h08
`define PS_PICK0       8'h14
`define PS_HYST0       8'h20
`define PS_BLIM0       8'h2C
`define PS_CALC_PICK   8'h38
`define PS_OPDLY       8'h3C
`define PS_RELDLY      8'h40
`define PS_STATUS      8'h44
`define PS_REMAIN      8'h48
`define PS_EXPECT      8'h4C
`define PS_SCALED0     8'h50
`define PS_RATIO0      8'h5C
`define PS_RATIO_CALC  8'h68
`define PS_STEP        8'h04

// ==========================================================================
// Field positions
`define PS_MODE_W      3
`define PS_ST_COND_LSB 4

// ==========================================================================
// Reset values
`define PS_CTRL_RST    3'h1
`define PS_MULT_RST    32'h00010000
`define PS_PICK_RST    32'h00000064
`define PS_HYST_RST    32'h00007530
`define PS_BLIM_RST    32'h80000000
`define PS_OPDLY_RST   32'h00000028
`define PS_RELDLY_RST  32'h0000003C

// ==========================================================================
// Fixed-point scales and timing
`define PS_MULT_FRAC   16
`define PS_UNIT        64'sh0000000000002710
`define PS_PCT_SCALE   64'sh00000000000F4240
`define PS_CLK_NS      4
`define PS_TICK_NS     1000000
`define PS_TICK_CYCLES (`PS_TICK_NS / `PS_CLK_NS)
`define PS_DELTA_MS    20

`endif

// *** include/ps_stage_pkg.sv ***
// Types shared by the programmable stage
package ps_stage_pkg;

  // ========================================================================
  // Comparator modes
  typedef enum logic [2:0] {
    PS_OVER          = 3'b000,
    PS_OVER_ABS      = 3'b001,
    PS_UNDER         = 3'b010,
    PS_UNDER_ABS     = 3'b011,
    PS_DELTA_REL     = 3'b100,
    PS_DELTA_REL_ABS = 3'b101,
    PS_DELTA_VAL     = 3'b110,
    PS_DELTA_VAL_ABS = 3'b111
  } ps_mode_t;

  // ========================================================================
  // Stage condition
  typedef enum logic [1:0] {
    PS_NORMAL  = 2'b00,
    PS_START   = 2'b01,
    PS_TRIP    = 2'b10,
    PS_BLOCKED = 2'b11
  } ps_cond_t;

endpackage

// *** core/ps_stage.sv ***
// Programmable protection stage with APB register access
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "ps_stage_map.svh"

module ps_stage #(
  parameter int TICK_CYCLES = `PS_TICK_CYCLES
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic signed [31:0] MEAS0,
  input wire logic signed [31:0] MEAS1,
  input wire logic signed [31:0] MEAS2,
  input wire logic BLOCK_IN,
  output logic START_OUT,
  output logic TRIP_OUT,
  output logic BLOCKED_OUT
);

  // ========================================================================
  // Declarations
  localparam int NCH = 3;
  localparam int HIST = `PS_DELTA_MS;

  logic [2:0] enable_r;
  logic [8:0] mode_r;
  logic signed [31:0] mult_r [NCH];
  logic signed [31:0] pick_r [NCH];
  logic signed [31:0] hyst_r [NCH];
  logic signed [31:0] blim_r [NCH];
  logic signed [31:0] calc_pick_r;
  logic [31:0] opdly_r;
  logic [31:0] reldly_r;
  logic signed [31:0] scaled_r [NCH];
  logic signed [31:0] ratio_r [NCH];
  logic signed [31:0] ratio_calc_r;
  logic signed [31:0] hist_r [NCH][HIST];
  logic [2:0] held_r;
  logic [2:0] cond_nxt;
  logic [31:0] tick_cnt_r;
  logic tick;
  logic block_s1_r;
  logic block_s2_r;
  ps_stage_pkg::ps_cond_t state_r;
  logic [31:0] remain_r;
  logic [31:0] rel_r;
  logic pick;
  logic signed [31:0] meas [NCH];
  logic signed [31:0] scaled_nxt [NCH];
  logic signed [31:0] calc_mag;
  logic [31:0] rdata_nxt;
  logic hit_nxt;
  logic wr_en;

  assign meas[0] = MEAS0;
  assign meas[1] = MEAS1;
  assign meas[2] = MEAS2;

  // ========================================================================
  // Helper functions
  function automatic logic signed [63:0] ps_abs(input logic signed [63:0] v);
    ps_abs = (v < 0) ? -v : v;
  endfunction

  // Fixed-point ratio with four decimals, zero for a zero setting
  function automatic logic signed [31:0] ps_ratio(input logic signed [31:0] v, input logic signed [31:0] s);
    logic signed [63:0] q;
    q = (s != 32'sh0) ? (64'(v) * `PS_UNIT) / 64'(s) : 64'sh0;
    ps_ratio = q[31:0];
  endfunction

  // Per-channel register hit: base offset plus one word per channel
  function automatic logic ps_at(input logic [7:0] a, input logic [7:0] base, input int i);
    ps_at = (a == base + 8'(i) * `PS_STEP);
  endfunction

  // Comparison with hysteresis once the condition is held
  function automatic logic ps_compare(input ps_stage_pkg::ps_mode_t md, input logic signed [63:0] x,
                                      input logic signed [63:0] dlt, input logic signed [63:0] old,
                                      input logic signed [63:0] p, input logic signed [63:0] hy,
                                      input logic signed [63:0] blim, input logic held);
    logic signed [63:0] q;
    logic signed [63:0] thr;
    logic signed [63:0] mg;
    logic under;
    logic inhibit;
    q = x;
    thr = p;
    under = 1'b0;
    inhibit = 1'b0;
    mg = (ps_abs(p) * hy) / `PS_PCT_SCALE;
    unique case (md)
      ps_stage_pkg::PS_OVER: q = x;
      ps_stage_pkg::PS_OVER_ABS: q = ps_abs(x);
      ps_stage_pkg::PS_UNDER: begin
        under = 1'b1;
        inhibit = x < blim;
      end
      ps_stage_pkg::PS_UNDER_ABS: begin
        q = ps_abs(x);
        under = 1'b1;
        inhibit = q < blim;
      end
      ps_stage_pkg::PS_DELTA_REL: begin
        q = dlt * `PS_PCT_SCALE;
        thr = p * ps_abs(old);
        mg = mg * ps_abs(old);
        under = p < 0;
      end
      ps_stage_pkg::PS_DELTA_REL_ABS: begin
        q = ps_abs(dlt) * `PS_PCT_SCALE;
        thr = ps_abs(p) * ps_abs(old);
        mg = mg * ps_abs(old);
      end
      ps_stage_pkg::PS_DELTA_VAL: begin
        q = dlt;
        under = p < 0;
      end
      ps_stage_pkg::PS_DELTA_VAL_ABS: begin
        q = ps_abs(dlt);
        thr = ps_abs(p);
      end
    endcase
    if (inhibit) begin
      ps_compare = 1'b0;
    end else if (under) begin
      ps_compare = held ? (q < thr + mg) : (q < thr);
    end else begin
      ps_compare = held ? (q > thr - mg) : (q > thr);
    end
  endfunction

  // ========================================================================
  // Program cycle tick
  always_ff @(posedge CLK) begin
    if (!RESETN || tick) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end
  assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

  // Blocking input synchroniser
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      block_s1_r <= 1'b0;
      block_s2_r <= 1'b0;
    end else begin
      block_s1_r <= BLOCK_IN;
      block_s2_r <= block_s1_r;
    end
  end

  // ========================================================================
  // Scaling, calculated magnitude and comparison
  always_comb begin
    logic signed [63:0] prod;
    prod = 64'sh0;
    calc_mag = 32'sh0;
    for (int i = 0; i < NCH; i++) begin
      prod = (64'(meas[i]) * 64'(mult_r[i])) >>> `PS_MULT_FRAC;
      scaled_nxt[i] = prod[31:0];
      if (enable_r[i]) begin
        calc_mag = calc_mag + prod[31:0];
      end
      cond_nxt[i] = enable_r[i] && ps_compare(ps_stage_pkg::ps_mode_t'(mode_r[i*`PS_MODE_W +: `PS_MODE_W]),
        64'(scaled_nxt[i]), 64'(scaled_nxt[i]) - 64'(hist_r[i][HIST-1]), 64'(hist_r[i][HIST-1]),
        64'(pick_r[i]), 64'(hyst_r[i]), 64'(blim_r[i]), held_r[i]);
    end
  end
  assign pick = |held_r;

  // Measurement pipeline, history and ratios, once per program cycle
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      held_r <= 3'h0;
      ratio_calc_r <= 32'sh0;
      for (int i = 0; i < NCH; i++) begin
        scaled_r[i] <= 32'sh0;
        ratio_r[i] <= 32'sh0;
        for (int j = 0; j < HIST; j++) begin
          hist_r[i][j] <= 32'sh0;
        end
      end
    end else if (tick) begin
      held_r <= cond_nxt;
      ratio_calc_r <= ps_ratio(calc_mag, calc_pick_r);
      for (int i = 0; i < NCH; i++) begin
        scaled_r[i] <= scaled_nxt[i];
        ratio_r[i] <= ps_ratio(scaled_nxt[i], pick_r[i]);
        hist_r[i][0] <= scaled_nxt[i];
        for (int j = 1; j < HIST; j++) begin
          hist_r[i][j] <= hist_r[i][j-1];
        end
      end
    end
  end

  // ========================================================================
  // Stage condition machine with operating and release timers
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      state_r <= ps_stage_pkg::PS_NORMAL;
      remain_r <= 32'h0;
      rel_r <= 32'h0;
    end else if (tick) begin
      unique case (state_r)
        ps_stage_pkg::PS_NORMAL: begin
          rel_r <= 32'h0;
          if (pick && block_s2_r) begin
            state_r <= ps_stage_pkg::PS_BLOCKED;
          end else if (pick) begin
            state_r <= ps_stage_pkg::PS_START;
            remain_r <= opdly_r;
          end
        end
        ps_stage_pkg::PS_START: begin
          if (block_s2_r || !pick) begin
            remain_r <= opdly_r;
            if (rel_r + 32'h1 >= reldly_r) begin
              state_r <= block_s2_r ? ps_stage_pkg::PS_BLOCKED : ps_stage_pkg::PS_NORMAL;
              rel_r <= 32'h0;
            end else begin
              rel_r <= rel_r + 32'h1;
            end
          end else begin
            rel_r <= 32'h0;
            if (remain_r <= 32'h1) begin
              state_r <= ps_stage_pkg::PS_TRIP;
              remain_r <= 32'h0;
            end else begin
              remain_r <= remain_r - 32'h1;
            end
          end
        end
        ps_stage_pkg::PS_TRIP: begin
          remain_r <= 32'h0;
          if (block_s2_r) begin
            state_r <= ps_stage_pkg::PS_BLOCKED;
          end else if (!pick) begin
            state_r <= ps_stage_pkg::PS_NORMAL;
          end
        end
        ps_stage_pkg::PS_BLOCKED: begin
          remain_r <= opdly_r;
          rel_r <= 32'h0;
          if (!block_s2_r) begin
            state_r <= pick ? ps_stage_pkg::PS_START : ps_stage_pkg::PS_NORMAL;
          end
        end
      endcase
    end
  end

  // Condition outputs
  assign START_OUT = (state_r == ps_stage_pkg::PS_START);
  assign TRIP_OUT = (state_r == ps_stage_pkg::PS_TRIP);
  assign BLOCKED_OUT = (state_r == ps_stage_pkg::PS_BLOCKED);

  // ========================================================================
  // APB slave: zero wait states, read data captured in the setup phase
  assign PREADY = 1'b1;
  assign wr_en = PSEL && PENABLE && PWRITE;

  // Settings writes
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      enable_r <= `PS_CTRL_RST;
      mode_r <= 9'h000;
      calc_pick_r <= `PS_PICK_RST;
      opdly_r <= `PS_OPDLY_RST;
      reldly_r <= `PS_RELDLY_RST;
      for (int i = 0; i < NCH; i++) begin
        mult_r[i] <= `PS_MULT_RST;
        pick_r[i] <= `PS_PICK_RST;
        hyst_r[i] <= `PS_HYST_RST;
        blim_r[i] <= `PS_BLIM_RST;
      end
    end else if (wr_en) begin
      if (PADDR == `PS_CTRL) enable_r <= PWDATA[2:0];
      if (PADDR == `PS_MODE) mode_r <= PWDATA[8:0];
      if (PADDR == `PS_CALC_PICK) calc_pick_r <= PWDATA;
      if (PADDR == `PS_OPDLY) opdly_r <= PWDATA;
      if (PADDR == `PS_RELDLY) reldly_r <= PWDATA;
      for (int i = 0; i < NCH; i++) begin
        if (ps_at(PADDR, `PS_MULT0, i)) mult_r[i] <= PWDATA;
        if (ps_at(PADDR, `PS_PICK0, i)) pick_r[i] <= PWDATA;
        if (ps_at(PADDR, `PS_HYST0, i)) hyst_r[i] <= PWDATA;
        if (ps_at(PADDR, `PS_BLIM0, i)) blim_r[i] <= PWDATA;
      end
    end
  end

  // Read decode and address check
  always_comb begin
    rdata_nxt = 32'h0;
    hit_nxt = 1'b1;
    unique case (PADDR)
      `PS_CTRL: rdata_nxt = {29'h0, enable_r};
      `PS_MODE: rdata_nxt = {23'h0, mode_r};
      `PS_CALC_PICK: rdata_nxt = calc_pick_r;
      `PS_OPDLY: rdata_nxt = opdly_r;
      `PS_RELDLY: rdata_nxt = reldly_r;
      `PS_STATUS: rdata_nxt = {25'h0, held_r, 2'h0, state_r};
      `PS_REMAIN: rdata_nxt = (state_r == ps_stage_pkg::PS_START) ? remain_r : 32'h0;
      `PS_EXPECT: rdata_nxt = opdly_r;
      `PS_RATIO_CALC: rdata_nxt = ratio_calc_r;
      default: begin
        hit_nxt = 1'b0;
        for (int i = 0; i < NCH; i++) begin
          if (ps_at(PADDR, `PS_MULT0, i)) rdata_nxt = mult_r[i];
          if (ps_at(PADDR, `PS_PICK0, i)) rdata_nxt = pick_r[i];
          if (ps_at(PADDR, `PS_HYST0, i)) rdata_nxt = hyst_r[i];
          if (ps_at(PADDR, `PS_BLIM0, i)) rdata_nxt = blim_r[i];
          if (ps_at(PADDR, `PS_SCALED0, i)) rdata_nxt = scaled_r[i];
          if (ps_at(PADDR, `PS_RATIO0, i)) rdata_nxt = ratio_r[i];
          hit_nxt = hit_nxt || ps_at(PADDR, `PS_MULT0, i) || ps_at(PADDR, `PS_PICK0, i) ||
            ps_at(PADDR, `PS_HYST0, i) || ps_at(PADDR, `PS_BLIM0, i) ||
            ps_at(PADDR, `PS_SCALED0, i) || ps_at(PADDR, `PS_RATIO0, i);
        end
      end
    endcase
  end

  // Read data and error flag latched at the setup cycle
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      PRDATA <= PWRITE ? 32'h0 : rdata_nxt;
      PSLVERR <= !hit_nxt || (PWRITE && PADDR >= `PS_STATUS);
    end
  end

endmodule // ps_stage

// *** test/ps_stage_asserts.sv ***
// Concurrent checks on the programmable stage ports
`timescale 1ns/1ps
`include "ps_stage_map.svh"

module ps_stage_asserts #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic BLOCK_IN,
  input wire logic START_OUT,
  input wire logic TRIP_OUT,
  input wire logic BLOCKED_OUT
);
  logic [2:0] outs_prev_r;
  logic [15:0] chg_age_r;
  logic [15:0] st_age_r;
  logic [3:0] blk_age_r;
  logic [31:0] opd_r;

  // ==========================================================================
  // Helper counters: output change spacing, start length, block age, delay copy
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      outs_prev_r <= 3'h0;
      chg_age_r <= 16'hFFFF;
      st_age_r <= 16'h0;
      blk_age_r <= 4'hF;
      opd_r <= `PS_OPDLY_RST;
    end else begin
      outs_prev_r <= {START_OUT, TRIP_OUT, BLOCKED_OUT};
      chg_age_r <= ({START_OUT, TRIP_OUT, BLOCKED_OUT} != outs_prev_r) ? 16'h0 :
                   chg_age_r + {15'h0, chg_age_r != 16'hFFFF};
      st_age_r <= START_OUT ? st_age_r + 16'h1 : 16'h0;
      blk_age_r <= BLOCK_IN ? 4'h0 : blk_age_r + {3'h0, blk_age_r != 4'hF};
      if (PSEL && PENABLE && PWRITE && PADDR == `PS_OPDLY) begin
        opd_r <= PWDATA;
      end
    end
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence s_setup_ro_wr;
    PSEL && !PENABLE && PWRITE && PADDR >= `PS_STATUS;
  endsequence
  sequence s_access;
    PSEL && PENABLE;
  endsequence
  property p_ready;
    PREADY;
  endproperty
  property p_ro_err;
    s_setup_ro_wr ##1 s_access |-> PSLVERR;
  endproperty
  property p_err_zero;
    s_access and !PWRITE && PSLVERR |-> PRDATA == 32'h0;
  endproperty
  property p_one_cond;
    $onehot0({START_OUT, TRIP_OUT, BLOCKED_OUT});
  endproperty
  property p_trip_from_start;
    $rose(TRIP_OUT) |-> $past(START_OUT);
  endproperty
  property p_trip_delay;
    $rose(TRIP_OUT) |-> st_age_r >= (opd_r - 32'h1) * TICK_CYCLES;
  endproperty
  property p_tick_spacing;
    ({START_OUT, TRIP_OUT, BLOCKED_OUT} != outs_prev_r) |-> chg_age_r >= TICK_CYCLES - 1;
  endproperty
  property p_block_rise;
    $rose(BLOCKED_OUT) |-> blk_age_r < 4'h4;
  endproperty
  property p_block_fall;
    $fell(BLOCKED_OUT) |-> blk_age_r != 4'h0;
  endproperty
  a_ready: assert property (p_ready) else $error("ready low");
  a_ro_err: assert property (p_ro_err) else $error("read-only write not refused");
  a_err_zero: assert property (p_err_zero) else $error("refused read data not zero");
  a_one_cond: assert property (p_one_cond) else $error("several conditions at once");
  a_trip_from_start: assert property (p_trip_from_start) else $error("trip without start");
  a_trip_delay: assert property (p_trip_delay) else $error("trip before operating delay");
  a_tick_spacing: assert property (p_tick_spacing) else $error("state change off tick");
  a_block_rise: assert property (p_block_rise) else $error("blocked without block");
  a_block_fall: assert property (p_block_fall) else $error("blocked left while block");
endmodule // ps_stage_asserts

bind ps_stage ps_stage_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .BLOCK_IN(BLOCK_IN), .START_OUT(START_OUT), .TRIP_OUT(TRIP_OUT),
  .BLOCKED_OUT(BLOCKED_OUT));

// *** test/ps_meas_model.sv ***
// Measurement source and blocking matrix model
`timescale 1ns/1ps

module ps_meas_model (
  input wire logic clk,
  input wire logic signed [31:0] m_set,
  input wire logic blk_set,
  output logic signed [31:0] meas0,
  output logic signed [31:0] meas1,
  output logic signed [31:0] meas2,
  output logic block_out
);
  // Start quiet so the stage sees defined values from time zero
  initial begin
    meas0 = 32'sh0;
    meas1 = 32'sh0;
    meas2 = 32'sh0;
    block_out = 1'b0;
  end

  // All channels follow the commanded value one clock later
  always @(posedge clk) begin
    meas0 <= m_set;
    meas1 <= m_set;
    meas2 <= m_set;
    block_out <= blk_set;
  end
endmodule // ps_meas_model

// *** test/ps_stage_tb.sv ***
// Self-checking bench for the programmable stage
`timescale 1ns/1ps
`include "ps_stage_map.svh"

module ps_stage_tb;
  localparam int TC = 4;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, START_OUT, TRIP_OUT, BLOCKED_OUT, BLOCK_IN;
  logic signed [31:0] MEAS0, MEAS1, MEAS2;
  logic signed [31:0] m_set = 32'sh0;
  logic blk_set = 1'b0;
  logic [31:0] rd;
  logic er;
  int errors = 0;
  int compares = 0;
  logic [7:0] ra [8] = '{`PS_CTRL, `PS_MODE, `PS_MULT0, `PS_PICK0, `PS_HYST0, `PS_OPDLY, `PS_RELDLY, `PS_EXPECT};
  logic [31:0] rv [8] = '{{29'h0, `PS_CTRL_RST}, 32'h0, `PS_MULT_RST, `PS_PICK_RST, `PS_HYST_RST,
    `PS_OPDLY_RST, `PS_RELDLY_RST, `PS_OPDLY_RST};
  logic [2:0] tm [13] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h4, 3'h5, 3'h6, 3'h7};
  int tb0 [13] = '{200, -200, -200, 50, -50, 10000, 10000, 10000, 10000, 20000, 20000, 20000, 20000};
  int tv [13] = '{200, -200, -200, 50, -50, 20000, 20000, 20000, 20000, 10000, 10000, 10000, 10000};
  logic [31:0] te [13] = '{32'h70, 32'h0, 32'h70, 32'h70, 32'h70, 32'h70, 32'h70, 32'h70, 32'h70,
    32'h0, 32'h70, 32'h0, 32'h70};

  // ==========================================================================
  // Design and measurement source
  ps_stage #(.TICK_CYCLES(TC)) dut_u (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .MEAS0(MEAS0), .MEAS1(MEAS1), .MEAS2(MEAS2), .BLOCK_IN(BLOCK_IN), .START_OUT(START_OUT),
    .TRIP_OUT(TRIP_OUT), .BLOCKED_OUT(BLOCKED_OUT));
  ps_meas_model meas_u (.clk(CLK), .m_set(m_set), .blk_set(blk_set), .meas0(MEAS0), .meas1(MEAS1),
    .meas2(MEAS2), .block_out(BLOCK_IN));

  // ==========================================================================
  // Tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rd & mask, exp);
  endtask

  task automatic tk(input int n);
    repeat (n * TC) @(posedge CLK);
  endtask

  // Bounded wait for a condition output: 0 start, 1 trip, 2 blocked
  task automatic wt(input int k, input logic v, input int n);
    logic s;
    s = ~v;
    for (int i = 0; i < n && s !== v; i++) begin
      @(posedge CLK);
      s = (k == 0) ? START_OUT : (k == 1) ? TRIP_OUT : BLOCKED_OUT;
    end
    cmp({31'h0, s}, {31'h0, v});
  endtask

  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock, watchdog and test sequence
  initial begin
    forever #2 CLK = ~CLK;
  end

  initial begin
    repeat (30000) @(posedge CLK);
    errors++;
    report_and_stop();
  end

  initial begin
    repeat (16) @(posedge CLK);
    RESETN <= 1'b1;
    foreach (ra[i]) chk(ra[i], 32'hFFFFFFFF, rv[i]);
    chk(8'h6C, 32'hFFFFFFFF, 32'h0);
    cmp({31'h0, er}, 32'h1);
    apb(1'b1, `PS_STATUS, 32'h3);
    cmp({31'h0, er}, 32'h1);
    apb(1'b1, `PS_OPDLY, 32'd100);
    apb(1'b1, `PS_RELDLY, 32'd2);
    apb(1'b1, `PS_CTRL, 32'h7);
    foreach (tm[i]) begin
      apb(1'b1, `PS_MODE, {23'h0, tm[i], tm[i], tm[i]});
      m_set <= tb0[i];
      tk(22);
      m_set <= tv[i];
      tk(3);
      chk(`PS_STATUS, 32'h70, te[i]);
    end
    apb(1'b1, `PS_CTRL, 32'h1);
    apb(1'b1, `PS_MODE, 32'h0);
    m_set <= 32'sd200;
    tk(3);
    m_set <= 32'sd99;
    tk(3);
    chk(`PS_STATUS, 32'h70, 32'h10);
    m_set <= 32'sd96;
    tk(3);
    chk(`PS_STATUS, 32'h70, 32'h0);
    apb(1'b1, `PS_MODE, 32'h2);
    apb(1'b1, `PS_BLIM0, 32'd60);
    m_set <= 32'sd50;
    tk(3);
    chk(`PS_STATUS, 32'h70, 32'h0);
    m_set <= 32'sd80;
    tk(3);
    chk(`PS_STATUS, 32'h70, 32'h10);
    apb(1'b1, `PS_MODE, 32'h0);
    m_set <= 32'sh0;
    wt(0, 1'b0, 60);
    wt(1, 1'b0, 60);
    m_set <= 32'sd200;
    wt(0, 1'b1, 40);
    chk(`PS_REMAIN, 32'hFFFFFFFF, 32'd100);
    chk(`PS_EXPECT, 32'hFFFFFFFF, 32'd100);
    m_set <= 32'sh0;
    repeat (4) @(posedge CLK);
    cmp({31'h0, START_OUT}, 32'h1);
    wt(0, 1'b0, 24);
    blk_set <= 1'b1;
    m_set <= 32'sd200;
    wt(2, 1'b1, 30);
    cmp({31'h0, START_OUT}, 32'h0);
    blk_set <= 1'b0;
    wt(0, 1'b1, 30);
    blk_set <= 1'b1;
    wt(2, 1'b1, 40);
    blk_set <= 1'b0;
    m_set <= 32'sh0;
    wt(2, 1'b0, 30);
    apb(1'b1, `PS_OPDLY, 32'd3);
    apb(1'b1, `PS_MULT0, 32'h00020000);
    m_set <= 32'sd200;
    wt(0, 1'b1, 40);
    wt(1, 1'b1, 24);
    chk(`PS_STATUS, 32'h3, 32'h2);
    chk(`PS_SCALED0, 32'hFFFFFFFF, 32'd400);
    chk(`PS_RATIO0, 32'hFFFFFFFF, 32'd40000);
    chk(`PS_RATIO_CALC, 32'hFFFFFFFF, 32'd40000);
    m_set <= 32'sh0;
    wt(1, 1'b0, 12);
    report_and_stop();
  end
endmodule // ps_stage_tb
